// ===== src/port_de_pkg.sv
// Constants, register map and carrier types of the port D / port E block.
// Assumes a 32-bit classic Wishbone master and one 25 MHz system clock.
package port_de_pkg;
    // ==========================================
    // Bus and register map (word aligned)
    localparam int         DATA_W      = 32;
    localparam int         ADR_W       = 8;
    localparam logic [7:0] OFS_D_LEVEL = 8'h00;
    localparam logic [7:0] OFS_D_LATCH = 8'h04;
    localparam logic [7:0] OFS_D_DIR   = 8'h08;
    localparam logic [7:0] OFS_E_LEVEL = 8'h0C;
    localparam logic [7:0] OFS_E_LATCH = 8'h10;
    localparam logic [7:0] OFS_E_DIR   = 8'h14;
    localparam logic [7:0] OFS_AN_CFG  = 8'h18;

    // ==========================================
    // Field positions and reset values
    localparam int         E_PINS      = 3;
    localparam int         BIT_D_PU    = 7;
    localparam int         BIT_E_PU    = 6;
    localparam int         AN_E_LSB    = 5;
    localparam int         AN_E_MSB    = 7;
    localparam int         D_SHARED    = 6;
    localparam logic [7:0] RST_LAT     = 8'h00;
    localparam logic [7:0] RST_DIR_D   = 8'hFF;
    localparam logic [2:0] RST_DIR_E   = 3'h7;
    localparam logic [7:0] RST_AN_CFG  = 8'h00;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [3:0]        sel;
        logic [ADR_W-1:0]  adr;
        logic [DATA_W-1:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic              ack;
        logic [DATA_W-1:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic [7:0] d;
        logic [2:0] e;
    } pin_in_t;

    typedef struct packed {
        logic [7:0] d_out;
        logic [7:0] d_oe;
        logic [7:0] d_pu;
        logic [2:0] e_out;
        logic [2:0] e_oe;
        logic [2:0] e_pu;
    } pin_drv_t;

    typedef struct packed {
        logic       parallel_master_active;
        logic       parallel_read_strobe;
        logic       parallel_write_strobe;
        logic       parallel_byte_enable;
        logic [2:0] parallel_strobe_oe;
        logic [1:0] parallel_data_out;
        logic [1:0] parallel_data_oe;
        logic [1:0] remap_out;
        logic [1:0] remap_oe;
    } periph_out_t;

    typedef struct packed {
        logic [1:0] parallel_data_in;
        logic [1:0] remap_in;
        logic       parallel_rd_in;
        logic       parallel_wr_in;
        logic [2:0] analog_channel_en;
    } periph_in_t;

    typedef struct packed {
        logic [7:0]        lat_d;
        logic [7:0]        dir_d;
        logic [2:0]        lat_e;
        logic [2:0]        dir_e;
        logic              pu_d;
        logic              pu_e;
        logic [7:0]        pin_analog_select;
        logic [7:0]        lvl_d;
        logic [2:0]        lvl_e;
        pin_drv_t          drv;
        logic              ack;
        logic [DATA_W-1:0] rdata;
    } state_t;
endpackage

// ===== src/port_de_gpio.sv
// Port D / port E pin logic with a classic Wishbone register slave.
// Assumes pins and peripheral signals synchronous to clk_sys.
module port_de_gpio
    import port_de_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire wb_req_t     wb_req,
    output wb_rsp_t          wb_rsp,
    input  wire pin_in_t     pins,
    output pin_drv_t         pin_drv,
    input  wire periph_out_t periph,
    output periph_in_t       periph_in
);
    // ==========================================
    // Elaboration check
    if (E_PINS != AN_E_MSB - AN_E_LSB + 1) begin : g_bad_map
        $error("analog select field does not match port E width");
    end

    // ==========================================
    // State and reset value
    localparam state_t ST_RST = '{
        lat_d: RST_LAT, dir_d: RST_DIR_D, lat_e: RST_LAT[2:0], dir_e: RST_DIR_E,
        pu_d: 1'b0, pu_e: 1'b0, pin_analog_select: RST_AN_CFG, lvl_d: 8'h00, lvl_e: 3'h0,
        drv: '0, ack: 1'b0, rdata: '0
    };

    state_t     st_ff;
    state_t     nxt_st;
    logic       acc;
    logic       wr_ok;
    logic [2:0] an_e;

    // Bus request not yet answered
    assign acc   = wb_req.cyc & wb_req.stb & ~st_ff.ack;
    assign wr_ok = acc & wb_req.we & wb_req.sel[0];
    // Analog pins of port E: select bit clear means analog
    assign an_e  = ~st_ff.pin_analog_select[AN_E_MSB:AN_E_LSB];

    // ==========================================
    // Next state
    always_comb begin
        logic [7:0] rv;
        rv         = 8'h00;
        nxt_st     = st_ff;
        nxt_st.ack = 1'b0;

        // Pin sampling; analog pins lose digital input
        nxt_st.lvl_d = pins.d;
        nxt_st.lvl_e = pins.e & ~an_e;

        // Read mux, unused bits stay zero
        case (wb_req.adr)
            OFS_D_LEVEL: rv = LARGE_PKG ? st_ff.lvl_d : 8'h00;
            OFS_D_LATCH: rv = LARGE_PKG ? st_ff.lat_d : 8'h00;
            OFS_D_DIR:   rv = LARGE_PKG ? st_ff.dir_d : 8'h00;
            OFS_E_LEVEL: rv = LARGE_PKG ? {5'h00, st_ff.lvl_e} : 8'h00;
            OFS_E_LATCH: rv = LARGE_PKG ? {5'h00, st_ff.lat_e} : 8'h00;
            OFS_E_DIR:   rv = LARGE_PKG ? {st_ff.pu_d, st_ff.pu_e, 3'h0, st_ff.dir_e} : 8'h00;
            OFS_AN_CFG:  rv = LARGE_PKG ? st_ff.pin_analog_select : {3'h0, st_ff.pin_analog_select[AN_E_LSB-1:0]};
            default:     rv = 8'h00;
        endcase
        if (acc) begin
            nxt_st.ack   = 1'b1;
            nxt_st.rdata = {24'h000000, rv};
        end

        // Register writes, lane 0 only
        if (wr_ok) begin
            case (wb_req.adr)
                OFS_D_LEVEL, OFS_D_LATCH: begin
                    if (LARGE_PKG) nxt_st.lat_d = wb_req.dat[7:0];
                end
                OFS_D_DIR: begin
                    if (LARGE_PKG) nxt_st.dir_d = wb_req.dat[7:0];
                end
                OFS_E_LEVEL, OFS_E_LATCH: begin
                    if (LARGE_PKG) nxt_st.lat_e = wb_req.dat[2:0];
                end
                OFS_E_DIR: begin
                    if (LARGE_PKG) begin
                        nxt_st.dir_e = wb_req.dat[2:0];
                        nxt_st.pu_e  = wb_req.dat[BIT_E_PU];
                        nxt_st.pu_d  = wb_req.dat[BIT_D_PU];
                    end
                end
                OFS_AN_CFG: begin
                    nxt_st.pin_analog_select = wb_req.dat[7:0];
                    if (!LARGE_PKG) nxt_st.pin_analog_select[AN_E_MSB:AN_E_LSB] = 3'h0;
                end
                default: ;
            endcase
        end

        // Port D drive: latch by direction, then shared functions
        nxt_st.drv.d_out = st_ff.lat_d;
        nxt_st.drv.d_oe  = ~st_ff.dir_d;
        for (int k = 0; k < 2; k++) begin
            if (periph.remap_oe[k]) begin
                nxt_st.drv.d_out[D_SHARED+k] = periph.remap_out[k];
                nxt_st.drv.d_oe[D_SHARED+k]  = 1'b1;
            end else if (periph.parallel_master_active) begin
                nxt_st.drv.d_out[D_SHARED+k] = periph.parallel_data_out[k];
                nxt_st.drv.d_oe[D_SHARED+k]  = periph.parallel_data_oe[k];
            end
        end

        // Port E drive; analog selection does not touch it
        if (periph.parallel_master_active) begin
            nxt_st.drv.e_out = {periph.parallel_byte_enable,
                                periph.parallel_write_strobe,
                                periph.parallel_read_strobe};
            nxt_st.drv.e_oe  = periph.parallel_strobe_oe;
        end else begin
            nxt_st.drv.e_out = st_ff.lat_e;
            nxt_st.drv.e_oe  = ~st_ff.dir_e;
        end

        // Pull-ups only on pins set as inputs
        nxt_st.drv.d_pu = {8{st_ff.pu_d}} & st_ff.dir_d;
        nxt_st.drv.e_pu = {E_PINS{st_ff.pu_e}} & st_ff.dir_e;
    end

    // Register the whole state
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================
    // Outputs
    assign wb_rsp.ack                  = st_ff.ack;
    assign wb_rsp.dat                  = st_ff.rdata;
    assign pin_drv                     = st_ff.drv;
    assign periph_in.parallel_data_in  = st_ff.lvl_d[7:6];
    assign periph_in.remap_in          = st_ff.lvl_d[7:6];
    assign periph_in.parallel_rd_in    = st_ff.lvl_e[0];
    assign periph_in.parallel_wr_in    = st_ff.lvl_e[1];
    assign periph_in.analog_channel_en = ~st_ff.pin_analog_select[AN_E_MSB:AN_E_LSB];

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence req_s;
        acc;
    endsequence
    sequence ack_pulse_s;
        st_ff.ack ##1 !st_ff.ack;
    endsequence
    sequence e_level_rd_s;
        acc && !wb_req.we && wb_req.adr == OFS_E_LEVEL;
    endsequence

    wb_ack_a: assert property (req_s |=> ack_pulse_s)
        else $error("bus ack is not a single pulse after request");

    e_dir_drive_a: assert property (
        !$past(periph.parallel_master_active) |->
            pin_drv.e_oe == ~$past(st_ff.dir_e) && pin_drv.e_out == $past(st_ff.lat_e))
        else $error("port E drive does not follow direction and latch");

    analog_zero_a: assert property (
        e_level_rd_s and ($past(st_ff.pin_analog_select[AN_E_MSB:AN_E_LSB]) == 3'h0)
            |=> wb_rsp.dat[7:0] == 8'h00)
        else $error("analog port E pin read as nonzero");

    reset_default_a: assert property (
        $past(reset) |-> st_ff.pin_analog_select == RST_AN_CFG && !st_ff.pu_d && !st_ff.pu_e
            && st_ff.dir_e == RST_DIR_E)
        else $error("reset defaults wrong");

    latch_read_a: assert property (
        acc && !wb_req.we && wb_req.adr == OFS_E_LATCH
            |=> wb_rsp.dat == {29'h0, $past(st_ff.lat_e)})
        else $error("latch read does not return latch");

    pullup_gate_a: assert property (
        pin_drv.d_pu == ({8{$past(st_ff.pu_d)}} & $past(st_ff.dir_d))
            && pin_drv.e_pu == ({3{$past(st_ff.pu_e)}} & $past(st_ff.dir_e)))
        else $error("pull-up enable wrong");

    unimpl_zero_a: assert property (
        e_level_rd_s |=> wb_rsp.dat[31:3] == 29'h0)
        else $error("unimplemented bits read nonzero");

    strobe_drive_a: assert property (
        $past(periph.parallel_master_active) |->
            pin_drv.e_out == $past({periph.parallel_byte_enable,
                periph.parallel_write_strobe, periph.parallel_read_strobe}))
        else $error("parallel strobes not on port E");

    remap_prio_a: assert property (
        $past(periph.remap_oe[0]) |->
            pin_drv.d_oe[6] && pin_drv.d_out[6] == $past(periph.remap_out[0]))
        else $error("remap output not on port D pin 6");

    remap_hi_a: assert property (
        $past(periph.remap_oe[1]) |->
            pin_drv.d_oe[7] && pin_drv.d_out[7] == $past(periph.remap_out[1]))
        else $error("remap output not on port D pin 7");

    pm_data_a: assert property (
        $past(periph.parallel_master_active && !periph.remap_oe[0]) |->
            pin_drv.d_oe[6] == $past(periph.parallel_data_oe[0])
            && pin_drv.d_out[6] == $past(periph.parallel_data_out[0]))
        else $error("parallel data not on port D pin 6");

    d_dir_drive_a: assert property (
        !$past(periph.parallel_master_active) && $past(periph.remap_oe) == 2'b00 |->
            pin_drv.d_oe == ~$past(st_ff.dir_d) && pin_drv.d_out == $past(st_ff.lat_d))
        else $error("port D drive does not follow direction and latch");

    analog_rd_a: assert property (
        !$past(st_ff.pin_analog_select[AN_E_LSB]) |-> !st_ff.lvl_e[0])
        else $error("analog port E pin 0 passes digital input");

    d_latch_map_a: assert property (
        wr_ok && wb_req.adr == OFS_D_LATCH && LARGE_PKG
            |=> ##1 pin_drv.d_out[5:0] == $past(wb_req.dat[5:0], 2))
        else $error("port D latch bits not on matching pins");
endmodule // port_de_gpio

// ===== bench/pin_model.sv
// Far-side pad model for the port D / port E block.
// Assumes pin_drv from the block and an external level driven by the bench.
module pin_model
    import port_de_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire pin_drv_t    drv,
    input  wire logic [10:0] ext,
    input  wire logic        ext_en,
    output pin_in_t          pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Pad resolution
    logic [10:0] wig_ff = 11'h555;
    wire  [10:0] oe = {drv.d_oe, drv.e_oe};
    wire  [10:0] pu = {drv.d_pu, drv.e_pu};
    // Undriven pads without pull-up wander every cycle
    always_ff @(posedge clk_sys) begin
        wig_ff <= ~wig_ff;
    end
    // Driver wins, then outside source, then pull-up
    assign pins = (oe & {drv.d_out, drv.e_out}) | (~oe & (ext_en ? ext : (pu | wig_ff)));
endmodule // pin_model

// ===== bench/port_de_gpio_tb.sv
// Self-checking bench of the port D / port E block against a register model.
// Assumes the package map and one 25 MHz clock.
module port_de_gpio_tb;
    import port_de_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Signals and model state
    logic clk_sys = 1'b0;
    logic reset   = 1'b1;
    wb_req_t     wb_req = '0;
    wb_rsp_t     wb_rsp;
    pin_in_t     pins;
    pin_drv_t    pin_drv;
    periph_out_t periph = '0;
    periph_in_t  periph_in;
    logic [10:0] ext = 11'h7FF;
    logic        ext_en = 1'b1;
    logic [31:0] r;
    logic [14:0] pr;
    int err_count, comparisons, v;
    int lat_d = 0, dir_d = 'hFF, lat_e = 0, dir_e = 7, pud = 0, pue = 0, an = 0;
    port_de_gpio u_dut (.clk_sys(clk_sys), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .pins(pins), .pin_drv(pin_drv), .periph(periph), .periph_in(periph_in));
    pin_model u_pins (.clk_sys(clk_sys), .drv(pin_drv), .ext(ext), .ext_en(ext_en), .pins(pins));
    // Clock
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_sys);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
        // Hold the request until ack; only the watchdog ends a hung wait
        do begin
            @(posedge clk_sys);
        end while (wb_rsp.ack !== 1'b1);
        r = wb_rsp.dat;
        wb_req <= '0;
    endtask
    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        chk(r, exp);
    endtask
    task automatic wr_rand(input logic [7:0] adr, input int keep, impl, output int val);
        int w;
        w = $urandom & keep;
        bus(1'b1, adr, w);
        val = w & impl;
    endtask
    task automatic check_all();
        logic [10:0] oe, out, ev, lv, pu;
        oe = {~dir_d[7:0], ~dir_e[2:0]};
        out = {lat_d[7:0], lat_e[2:0]};
        pu = {{8{pud[0]}} & dir_d[7:0], {3{pue[0]}} & dir_e[2:0]};
        if (periph.parallel_master_active) begin
            oe[2:0] = periph.parallel_strobe_oe;
            out[2:0] = {periph.parallel_byte_enable, periph.parallel_write_strobe,
                        periph.parallel_read_strobe};
            oe[10:9] = periph.parallel_data_oe;
            out[10:9] = periph.parallel_data_out;
        end
        for (int k = 0; k < 2; k++) begin
            if (periph.remap_oe[k]) begin
                oe[9+k] = 1'b1;
                out[9+k] = periph.remap_out[k];
            end
        end
        ev = ext_en ? ext : 11'h7FF;
        lv = (oe & out) | (~oe & ev);
        repeat (3) @(posedge clk_sys);
        chk({pin_drv.d_oe, pin_drv.e_oe}, oe);
        chk({pin_drv.d_out, pin_drv.e_out} & oe, out & oe);
        chk({pin_drv.d_pu, pin_drv.e_pu}, pu);
        chk(periph_in, {lv[10:9], lv[10:9], lv[0] & an[5], lv[1] & an[6], ~an[7:5]});
        rdc(OFS_D_LATCH, lat_d);
        rdc(OFS_D_DIR, dir_d);
        rdc(OFS_E_LATCH, lat_e);
        rdc(OFS_E_DIR, {pud[0], pue[0], 3'h0, dir_e[2:0]});
        rdc(OFS_AN_CFG, an);
        rdc(OFS_D_LEVEL, lv[10:3]);
        rdc(OFS_E_LEVEL, lv[2:0] & an[7:5]);
        rdc(8'h1C, 32'h0);
    endtask
    task automatic results();
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ==========================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        results();
    end
    // Main sequence: reset state, random traffic, then floating pull-ups
    initial begin
        void'($urandom(32'h54DE));
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        check_all();
        for (int i = 0; i < 24; i++) begin
            pr = 15'($urandom);
            periph <= (i < 12) ? '0 : pr;
            ext <= 11'($urandom);
            wr_rand(($urandom & 1) ? OFS_D_LEVEL : OFS_D_LATCH, -1, 'hFF, lat_d);
            wr_rand(OFS_D_DIR, -1, 'hFF, dir_d);
            wr_rand(($urandom & 1) ? OFS_E_LEVEL : OFS_E_LATCH, -1, 7, lat_e);
            wr_rand(OFS_E_DIR, (i < 12) ? -1 : 'h3F, 'hC7, v);
            dir_e = v & 7;
            pue = (v >> 6) & 1;
            pud = (v >> 7) & 1;
            wr_rand(OFS_AN_CFG, -1, 'hFF, an);
            bus(1'b1, 8'h1C, $urandom);
            check_all();
        end
        periph <= '0;
        ext_en <= 1'b0;
        bus(1'b1, OFS_D_DIR, 32'hFF);
        bus(1'b1, OFS_E_DIR, 32'hC7);
        bus(1'b1, OFS_AN_CFG, 32'hE0);
        dir_d = 'hFF;
        dir_e = 7;
        pud = 1;
        pue = 1;
        an = 'hE0;
        check_all();
        results();
    end
endmodule // port_de_gpio_tb
